// ### bench/t16mt_pins.sv
module t16mt_pins (
	input  wire        clk_i,
	input  wire        pin_a_i,
	output logic [7:0] edges_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       last_ff;
	logic [7:0] cnt_ff = 8'h00;
	assign edges_o = cnt_ff;
	// External load; counts every level change it sees on pin a
	always @(posedge clk_i) begin
		if (pin_a_i !== last_ff)
			cnt_ff <= cnt_ff + 8'h01;
		last_ff <= pin_a_i;
	end
endmodule // t16mt_pins

// ### bench/t16mt_top_properties.sv
`include "t16mt_regs.vh"
module t16mt_top_properties #(
	parameter CW = 16,
	parameter AW = 12
) (
	input wire          clk_i,
	input wire          rst_i,
	input wire          cyc_i,
	input wire          stb_i,
	input wire          we_i,
	input wire [AW-1:0] adr_i,
	input wire [3:0]    sel_i,
	input wire [31:0]   dat_i,
	input wire          cap0_load_i,
	input wire          cap1_load_i,
	input wire          ack_o,
	input wire [31:0]   dat_o,
	input wire          irq_o,
	input wire          match0_irq_o,
	input wire          match1_irq_o,
	input wire          timer_pin_a_o,
	input wire          timer_pin_b_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire req = cyc_i && stb_i && ack_o;
	wire ffc = req && adr_i[AW-1:2] == `T16MT_IDX_FFCR;
	wire ffw = ffc && we_i && sel_i[0];
	wire iew = req && we_i && adr_i[AW-1:2] == `T16MT_IDX_IEN;
	property p_ack_rsp; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
	a_ack_rsp: assert property (p_ack_rsp) else $error("ack late");
	property p_ack_pls; ack_o |=> !ack_o; endproperty
	a_ack_pls: assert property (p_ack_pls) else $error("ack too long");
	property p_rst;
		disable iff (1'b0) rst_i |=> !ack_o && !irq_o && !match0_irq_o;
	endproperty
	a_rst: assert property (p_rst) else $error("reset outputs");
	property p_set_a; ffw && dat_i[1:0] == 2'h1 |=> timer_pin_a_o; endproperty
	a_set_a: assert property (p_set_a) else $error("set a");
	property p_clr_b; ffw && dat_i[7:6] == 2'h2 |=> !timer_pin_b_o; endproperty
	a_clr_b: assert property (p_clr_b) else $error("clear b");
	property p_inv_a;
		ffw && dat_i[1:0] == 2'h0 |=> timer_pin_a_o != $past(timer_pin_a_o);
	endproperty
	a_inv_a: assert property (p_inv_a) else $error("invert a");
	property p_rd_cmd;
		ffc && !we_i |-> dat_o[7:6] == 2'h3 && dat_o[1:0] == 2'h3;
	endproperty
	a_rd_cmd: assert property (p_rd_cmd) else $error("cmd read");
	property p_m0; match0_irq_o |=> !match0_irq_o; endproperty
	a_m0: assert property (p_m0) else $error("match0 pulse");
	property p_m1; match1_irq_o |-> !$past(match1_irq_o); endproperty
	a_m1: assert property (p_m1) else $error("match1 pulse");
	property p_irq;
		$rose(irq_o) |-> match0_irq_o || match1_irq_o || $past(iew)
			|| $past(iew, 2);
	endproperty
	a_irq: assert property (p_irq) else $error("irq cause");
endmodule // t16mt_top_properties
bind t16mt_top t16mt_top_properties #(.CW(CW), .AW(AW)) t16mt_top_prop_inst (
	.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
	.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .cap0_load_i(cap0_load_i),
	.cap1_load_i(cap1_load_i), .ack_o(ack_o), .dat_o(dat_o), .irq_o(irq_o),
	.match0_irq_o(match0_irq_o), .match1_irq_o(match1_irq_o),
	.timer_pin_a_o(timer_pin_a_o), .timer_pin_b_o(timer_pin_b_o));

// ### bench/tb_t16mt_top.sv
`include "t16mt_regs.vh"
module tb_t16mt_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i, rst_i, cyc_i, stb_i, we_i, cap0_load_i, cap1_load_i;
	logic [11:0] adr_i;
	logic [3:0]  sel_i;
	logic [31:0] dat_i, q;
	wire         ack_o, irq_o, match0_irq_o, match1_irq_o, pin_a, pin_b;
	wire  [31:0] dat_o;
	wire  [7:0]  edges;
	int          err_total, n_checks, cyc_cnt;
	logic        p;
	logic [1:0]  codes [4] = '{2'h1, 2'h2, 2'h0, 2'h3};
	t16mt_top t16mt_top_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
		.dat_i(dat_i), .cap0_load_i(cap0_load_i), .cap1_load_i(cap1_load_i),
		.ack_o(ack_o), .dat_o(dat_o), .irq_o(irq_o),
		.match0_irq_o(match0_irq_o), .match1_irq_o(match1_irq_o),
		.timer_pin_a_o(pin_a), .timer_pin_b_o(pin_b));
	t16mt_pins t16mt_pins_inst (.clk_i(clk_i), .pin_a_i(pin_a),
		.edges_o(edges));
	task automatic print_verdict;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	// Cap pulse meets the ack edge, where the write lands
	task automatic wb(input logic w, input logic [9:0] ix, input logic [31:0] d,
		input logic c);
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, ix, 2'b00, d};
		@(posedge clk_i);
		cap0_load_i <= c;
		while (ack_o !== 1'b1)
			@(posedge clk_i);
		q = dat_o;
		cap0_load_i <= 1'b0;
		{cyc_i, stb_i, we_i} <= 3'b000;
	endtask
	task automatic cap(input logic [1:0] m);
		@(posedge clk_i);
		{cap1_load_i, cap0_load_i} <= m;
		@(posedge clk_i);
		{cap1_load_i, cap0_load_i} <= 2'b00;
		repeat (2) @(posedge clk_i);
	endtask
	task automatic wm(input logic b);
		for (int i = 0; i < 200 && (b ? match1_irq_o : match0_irq_o) !== 1'b1;
			i++)
			@(posedge clk_i);
	endtask
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc_cnt <= cyc_cnt + 1;
		// Whole run needs well under a thousand cycles
		if (cyc_cnt == 5000) begin
			err_total++;
			print_verdict();
		end
	end
	initial begin
		{rst_i, cyc_i, stb_i, we_i, cap0_load_i, cap1_load_i} = 6'b100000;
		{adr_i, sel_i, dat_i, cyc_cnt} = '0;
		sel_i = 4'hF;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(0, `T16MT_IDX_FFCR, 0, 0); chk(q, 32'h000000C3);
		wb(0, 10'h3FF, 0, 0); chk(q, 32'h00000000);
		foreach (codes[i]) begin
			wb(1, `T16MT_IDX_FFCR, {24'h0, codes[i], 4'h0, codes[i]}, 0);
			p = codes[i] == 2'h1 ? 1'b1 : codes[i] == 2'h2 ? 1'b0 :
				codes[i] == 2'h0 ? ~p : p;
			@(posedge clk_i);
			chk({pin_a, pin_b}, {30'h0, p, p});
		end
		wb(1, `T16MT_IDX_FFCR, 32'h000000D3, 0);
		wb(0, `T16MT_IDX_FFCR, 0, 0); chk(q, 32'h000000D3);
		cap(2'b01); chk(pin_a, 32'h0);
		cap(2'b10); chk(pin_a, 32'h0);
		wb(1, `T16MT_IDX_FFCR, 32'h000000D1, 0);
		wb(1, `T16MT_IDX_FFCR, 32'h000000D1, 1);
		repeat (3) @(posedge clk_i);
		chk(pin_a, 32'h1);
		wb(1, `T16MT_IDX_CMP0, 32'h00000010, 0);
		wb(1, `T16MT_IDX_CMP1, 32'h00000030, 0);
		wb(1, `T16MT_IDX_FFCR, 32'h000000C7, 0);
		wb(1, `T16MT_IDX_TRIGB, 32'h00000002, 0);
		wb(1, `T16MT_IDX_IEN, 32'h00000003, 0);
		wb(1, `T16MT_IDX_RUN, 32'h00000001, 0);
		wm(0); chk({match0_irq_o, irq_o, pin_a, pin_b}, 32'hD);
		wm(1); chk({match1_irq_o, irq_o, pin_a, pin_b}, 32'hC);
		wb(0, `T16MT_IDX_ISTAT, 0, 0); chk(q, 32'h3);
		wb(1, `T16MT_IDX_ICLR, 32'h1, 0);
		wb(0, `T16MT_IDX_ISTAT, 0, 0); chk({q[30:0], irq_o}, 32'h5);
		wb(1, `T16MT_IDX_IEN, 32'h1, 0);
		repeat (3) @(posedge clk_i);
		chk(irq_o, 32'h0);
		wb(1, `T16MT_IDX_ICLR, 32'h2, 0);
		wb(0, `T16MT_IDX_ISTAT, 0, 0); chk(q, 32'h0);
		chk(edges != 8'h00, 32'h1);
		print_verdict();
	end
endmodule // tb_t16mt_top

// ### rtl/t16mt_cmp.v
`include "t16mt_regs.vh"

// One pulse per arrival at equality; a stopped counter sitting on the
// compare value does not flood the interrupt logic.
module t16mt_cmp #(
	parameter CW = 16
) (
	input  wire          clk_i,
	input  wire          rst_i,
	input  wire [CW-1:0] count_i,
	input  wire [CW-1:0] value_i,
	output wire          match_o
);
	reg  eq_prev_ff;
	reg  match_ff;
	wire eq;

	assign eq = (count_i == value_i);

	always @(posedge clk_i) begin
		if (rst_i) begin
			eq_prev_ff <= 1'b0;
			match_ff   <= 1'b0;
		end else begin
			eq_prev_ff <= eq;
			match_ff   <= eq & ~eq_prev_ff;
		end
	end

	assign match_o = match_ff;
endmodule // t16mt_cmp

// ### rtl/t16mt_toggle.v
`include "t16mt_regs.vh"

module t16mt_toggle (
	input  wire                     clk_i,
	input  wire                     cmd_we_i,
	input  wire [1:0]               cmd_i,
	input  wire [`T16MT_TRIG_W-1:0] trig_en_i,
	input  wire [`T16MT_TRIG_W-1:0] event_i,
	output wire                     q_o
);
	reg q_ff;

	// No reset: state is left undefined until software sets it
	always @(posedge clk_i) begin
		if (cmd_we_i && cmd_i != `T16MT_CMD_KEEP) begin
			case (cmd_i)
				`T16MT_CMD_INV: q_ff <= ~q_ff;
				`T16MT_CMD_SET: q_ff <= 1'b1;
				`T16MT_CMD_CLR: q_ff <= 1'b0;
				default:        q_ff <= q_ff;
			endcase
		end else if (|(trig_en_i & event_i)) begin
			q_ff <= ~q_ff;
		end
	end

	assign q_o = q_ff;
endmodule // t16mt_toggle

// ### rtl/t16mt_top.v
// Functional notes
// - Two 16-bit comparators watch counter against compares.
// - Each comparator match raises its own interrupt.
// - Flip-flops invert on matches and capture loads.
// - Four enable bits gate first flip-flop inversion.
// - Output flip-flops have no reset value.
// - Command 00 invert, 01 set, 10 clear, 11 keep.
// - Flip-flop states drive their timer output pins.
//
// Added by the designer: the Wishbone slave port.
`include "t16mt_regs.vh"

module t16mt_top #(
	parameter CW = 16,
	parameter AW = 12
) (
	input  wire          clk_i,
	input  wire          rst_i,
	input  wire          cyc_i,
	input  wire          stb_i,
	input  wire          we_i,
	input  wire [AW-1:0] adr_i,
	input  wire [3:0]    sel_i,
	input  wire [31:0]   dat_i,
	input  wire          cap0_load_i,
	input  wire          cap1_load_i,
	output wire          ack_o,
	output wire [31:0]   dat_o,
	output wire          irq_o,
	output wire          match0_irq_o,
	output wire          match1_irq_o,
	output wire          timer_pin_a_o,
	output wire          timer_pin_b_o
);
	// Bus state
	reg                      ack_ff;
	reg  [31:0]              rdata_ff;
	reg  [31:0]              nxt_rdata;

	// Timer state
	reg                      run_ff;
	reg  [CW-1:0]            up_counter16_ff;
	reg  [CW-1:0]            compare_value0_ff;
	reg  [CW-1:0]            compare_value1_ff;
	reg  [CW-1:0]            capture_value0_ff;
	reg  [CW-1:0]            capture_value1_ff;
	reg  [`T16MT_TRIG_W-1:0] trig_a_ff;
	reg  [`T16MT_TRIG_W-1:0] trig_b_ff;

	// Interrupt state
	reg  [`T16MT_IRQ_W-1:0]  istat_ff;
	reg  [`T16MT_IRQ_W-1:0]  ien_ff;
	reg  [`T16MT_IRQ_W-1:0]  nxt_istat;
	reg                      irq_ff;
	reg                      m0_irq_ff;
	reg                      m1_irq_ff;

	wire                     req;
	wire                     take;
	wire                     wr_go;
	wire [`T16MT_IDX_W-1:0]  idx;
	wire [1:0]               match;
	wire [`T16MT_TRIG_W-1:0] events;
	wire [1:0]               cmd_we;
	wire [3:0]               cmd_pair;
	wire [7:0]               trig_pair;
	wire [1:0]               ff_q;
	wire [`T16MT_IRQ_W-1:0]  irq_set;
	wire                     iclr_go;

	function is_idx;
		input [`T16MT_IDX_W-1:0] a;
		input [`T16MT_IDX_W-1:0] b;
		begin
			is_idx = (a == b);
		end
	endfunction

	// Acked write on lane 0 to one register index
	function wr_hit;
		input [`T16MT_IDX_W-1:0] a;
		input [`T16MT_IDX_W-1:0] b;
		input                    go;
		input                    lane;
		begin
			wr_hit = go & lane & (a == b);
		end
	endfunction

	// Byte-lane merge for 16-bit registers
	function [15:0] merge16;
		input [15:0] old;
		input [31:0] wdat;
		input [3:0]  sel;
		begin
			merge16[7:0]  = sel[0] ? wdat[7:0]  : old[7:0];
			merge16[15:8] = sel[1] ? wdat[15:8] : old[15:8];
		end
	endfunction

	assign idx   = adr_i[`T16MT_IDX_W+1:2];
	assign req   = cyc_i & stb_i;
	assign take  = req & ~ack_ff;
	// Writes land on the edge where the master sees ack
	assign wr_go = req & we_i & ack_ff;

	// One wait state: ack one cycle after strobe, gone the next
	// A new request is taken only once ack has dropped
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= take;
		end
	end

	// Unmapped indices read zero; writes there are dropped
	always @* begin
		nxt_rdata = 32'h0000_0000;
		if (is_idx(idx, `T16MT_IDX_RUN)) begin
			nxt_rdata[`T16MT_RUN_BIT] = run_ff;
		end else if (is_idx(idx, `T16MT_IDX_FFCR)) begin
			nxt_rdata[`T16MT_CMDB_HI:`T16MT_CMDB_LO] = `T16MT_CMD_KEEP;
			nxt_rdata[`T16MT_TRIG_HI:`T16MT_TRIG_LO] = trig_a_ff;
			nxt_rdata[`T16MT_CMDA_HI:`T16MT_CMDA_LO] = `T16MT_CMD_KEEP;
		end else if (is_idx(idx, `T16MT_IDX_CMP0)) begin
			nxt_rdata[CW-1:0] = compare_value0_ff;
		end else if (is_idx(idx, `T16MT_IDX_CMP1)) begin
			nxt_rdata[CW-1:0] = compare_value1_ff;
		end else if (is_idx(idx, `T16MT_IDX_CAP0)) begin
			nxt_rdata[CW-1:0] = capture_value0_ff;
		end else if (is_idx(idx, `T16MT_IDX_CAP1)) begin
			nxt_rdata[CW-1:0] = capture_value1_ff;
		end else if (is_idx(idx, `T16MT_IDX_COUNT)) begin
			nxt_rdata[CW-1:0] = up_counter16_ff;
		end else if (is_idx(idx, `T16MT_IDX_ISTAT)) begin
			nxt_rdata[`T16MT_IRQ_W-1:0] = istat_ff;
		end else if (is_idx(idx, `T16MT_IDX_IEN)) begin
			nxt_rdata[`T16MT_IRQ_W-1:0] = ien_ff;
		end else if (is_idx(idx, `T16MT_IDX_TRIGB)) begin
			nxt_rdata[`T16MT_TRIG_W-1:0] = trig_b_ff;
		end
	end

	// Read data is captured as the request is taken, so it is
	// stable in the cycle ack is high
	always @(posedge clk_i) begin
		if (rst_i) begin
			rdata_ff <= 32'h0000_0000;
		end else if (take) begin
			rdata_ff <= nxt_rdata;
		end
	end

	// Software-writable control
	always @(posedge clk_i) begin
		if (rst_i) begin
			run_ff            <= `T16MT_RST_RUN;
			compare_value0_ff <= `T16MT_RST_CMP;
			compare_value1_ff <= `T16MT_RST_CMP;
			trig_a_ff         <= `T16MT_RST_TRIG;
			trig_b_ff         <= `T16MT_RST_TRIG;
			ien_ff            <= `T16MT_RST_IRQ;
		end else if (wr_go) begin
			if (is_idx(idx, `T16MT_IDX_RUN) && sel_i[0]) begin
				run_ff <= dat_i[`T16MT_RUN_BIT];
			end
			if (is_idx(idx, `T16MT_IDX_FFCR) && sel_i[0]) begin
				trig_a_ff <= dat_i[`T16MT_TRIG_HI:`T16MT_TRIG_LO];
			end
			if (is_idx(idx, `T16MT_IDX_CMP0)) begin
				compare_value0_ff <=
					merge16(compare_value0_ff, dat_i, sel_i);
			end
			if (is_idx(idx, `T16MT_IDX_CMP1)) begin
				compare_value1_ff <=
					merge16(compare_value1_ff, dat_i, sel_i);
			end
			if (is_idx(idx, `T16MT_IDX_IEN) && sel_i[0]) begin
				ien_ff <= dat_i[`T16MT_IRQ_W-1:0];
			end
			if (is_idx(idx, `T16MT_IDX_TRIGB) && sel_i[0]) begin
				trig_b_ff <= dat_i[`T16MT_TRIG_W-1:0];
			end
		end
	end

	// Up counter, counts while run is set, wraps at full scale
	always @(posedge clk_i) begin
		if (rst_i) begin
			up_counter16_ff <= `T16MT_RST_CNT;
		end else if (run_ff) begin
			up_counter16_ff <= up_counter16_ff + 1'b1;
		end
	end

	// Capture registers latch the counter on their load strobes
	// Strobes come from this clock, so they need no synchroniser
	always @(posedge clk_i) begin
		if (rst_i) begin
			capture_value0_ff <= `T16MT_RST_CNT;
			capture_value1_ff <= `T16MT_RST_CNT;
		end else begin
			if (cap0_load_i) begin
				capture_value0_ff <= up_counter16_ff;
			end
			if (cap1_load_i) begin
				capture_value1_ff <= up_counter16_ff;
			end
		end
	end

	t16mt_cmp #(
		.CW      (CW)
	) u_comparator_unit0 ( // Registered match keeps pins and irqs aligned
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.count_i (up_counter16_ff),
		.value_i (compare_value0_ff),
		.match_o (match[0])
	);

	t16mt_cmp #(
		.CW      (CW)
	) u_comparator_unit1 (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.count_i (up_counter16_ff),
		.value_i (compare_value1_ff),
		.match_o (match[1])
	);

	// Events in one cycle invert a flip-flop once, not per event
	assign events[`T16MT_TRIG_CMP0] = match[0];
	assign events[`T16MT_TRIG_CMP1] = match[1];
	assign events[`T16MT_TRIG_CAP0] = cap0_load_i;
	assign events[`T16MT_TRIG_CAP1] = cap1_load_i;

	// Command writes act once, on the acked write only; both
	// fields sit in byte lane 0, so one strobe serves both
	assign cmd_we[0] = wr_hit(idx, `T16MT_IDX_FFCR, wr_go, sel_i[0]);
	assign cmd_we[1] = cmd_we[0];
	assign cmd_pair  = {dat_i[`T16MT_CMDB_HI:`T16MT_CMDB_LO],
			dat_i[`T16MT_CMDA_HI:`T16MT_CMDA_LO]};
	assign trig_pair = {trig_b_ff, trig_a_ff};

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_tff
			t16mt_toggle u_tff (
				.clk_i     (clk_i),
				.cmd_we_i  (cmd_we[g]),
				.cmd_i     (cmd_pair[2*g+1:2*g]),
				.trig_en_i (trig_pair[4*g+3:4*g]),
				.event_i   (events),
				.q_o       (ff_q[g])
			);
		end
	endgenerate

	// Pins come straight from the toggle flip-flops; port muxing
	// outside picks timer or port function
	assign timer_pin_a_o = ff_q[0];
	assign timer_pin_b_o = ff_q[1];

	// Sticky status; a match in the clearing cycle survives
	assign irq_set[`T16MT_IRQ_M0] = match[0];
	assign irq_set[`T16MT_IRQ_M1] = match[1];
	assign iclr_go = wr_hit(idx, `T16MT_IDX_ICLR, wr_go, sel_i[0]);

	always @* begin
		nxt_istat = istat_ff;
		if (iclr_go) begin
			nxt_istat = istat_ff & ~dat_i[`T16MT_IRQ_W-1:0];
		end
		nxt_istat = nxt_istat | irq_set;
	end

	// Level output updates on the same edge as status; enable changes show one edge later
	always @(posedge clk_i) begin
		if (rst_i) begin
			istat_ff  <= `T16MT_RST_IRQ;
			irq_ff    <= 1'b0;
			m0_irq_ff <= 1'b0;
			m1_irq_ff <= 1'b0;
		end else begin
			istat_ff  <= nxt_istat;
			irq_ff    <= |(nxt_istat & ien_ff);
			m0_irq_ff <= match[0];
			m1_irq_ff <= match[1];
		end
	end

	assign ack_o        = ack_ff;
	assign dat_o        = rdata_ff;
	assign irq_o        = irq_ff;
	assign match0_irq_o = m0_irq_ff;
	assign match1_irq_o = m1_irq_ff;
endmodule // t16mt_top

// ### shared/t16mt_regs.vh
`ifndef T16MT_REGS_VH
`define T16MT_REGS_VH

// Register indices; byte address is four times the index
`define T16MT_IDX_W        10
`define T16MT_IDX_RUN      10'h180
`define T16MT_IDX_FFCR     10'h183
`define T16MT_IDX_CMP0     10'h184
`define T16MT_IDX_CMP1     10'h185
`define T16MT_IDX_CAP0     10'h186
`define T16MT_IDX_CAP1     10'h187
`define T16MT_IDX_COUNT    10'h188
`define T16MT_IDX_ISTAT    10'h189
`define T16MT_IDX_ICLR     10'h18A
`define T16MT_IDX_IEN      10'h18B
`define T16MT_IDX_TRIGB    10'h18C

// Run control bit
`define T16MT_RUN_BIT      0

// Toggle control field layout
`define T16MT_CMDB_HI      7
`define T16MT_CMDB_LO      6
`define T16MT_TRIG_HI      5
`define T16MT_TRIG_LO      2
`define T16MT_CMDA_HI      1
`define T16MT_CMDA_LO      0

// Toggle commands
`define T16MT_CMD_INV      2'h0
`define T16MT_CMD_SET      2'h1
`define T16MT_CMD_CLR      2'h2
`define T16MT_CMD_KEEP     2'h3

// Trigger enable bit order inside the four-bit group
`define T16MT_TRIG_CMP0    0
`define T16MT_TRIG_CMP1    1
`define T16MT_TRIG_CAP0    2
`define T16MT_TRIG_CAP1    3
`define T16MT_TRIG_W       4

// Interrupt status layout
`define T16MT_IRQ_W        2
`define T16MT_IRQ_M0       0
`define T16MT_IRQ_M1       1

// Reset values
`define T16MT_RST_TRIG     4'h0
`define T16MT_RST_IRQ      2'h0
`define T16MT_RST_RUN      1'h0
`define T16MT_RST_CNT      16'h0000
`define T16MT_RST_CMP      16'hFFFF

`endif
